// File: rtl/cmd_pkg.sv
// Purpose: shared constants and carriers for the motion command interpreter
// Assumes: one clock, byte-wide frame input from same-clock logic
// Notes:   opcodes, frame layout, status codes and axis modes live here
package cmd_pkg;

  // frame layout
  localparam int unsigned FRAME_BYTES = 9;
  localparam logic [3:0]  IDX_ADDR    = 4'h0;
  localparam logic [3:0]  IDX_INSTR   = 4'h1;
  localparam logic [3:0]  IDX_TYPE    = 4'h2;
  localparam logic [3:0]  IDX_AXIS    = 4'h3;
  localparam logic [3:0]  IDX_VAL3    = 4'h4;
  localparam logic [3:0]  IDX_CSUM    = 4'h8;

  // base opcodes
  localparam logic [7:0] OP_ROTATE_INCREASING = 8'h01;
  localparam logic [7:0] OP_ROTATE_DECREASING = 8'h02;
  localparam logic [7:0] OP_AXIS_SOFT_HALT    = 8'h03;
  // extended opcodes (decimal values as printed: 16..18, 40..57, 80)
  localparam logic [7:0] OP_SET_AP_X    = 8'h10;
  localparam logic [7:0] OP_GET_AP_X    = 8'h11;
  localparam logic [7:0] OP_ACCU_AP_X   = 8'h12;
  localparam logic [7:0] OP_CALC_VV     = 8'h28;
  localparam logic [7:0] OP_CALC_V      = 8'h2D;
  localparam logic [7:0] OP_MOVE_A      = 8'h2E;
  localparam logic [7:0] OP_MOVE_XA     = 8'h2F;
  localparam logic [7:0] OP_RESTART     = 8'h30;
  localparam logic [7:0] OP_DEC_BRANCH  = 8'h31;
  localparam logic [7:0] OP_ROT_DEC_A   = 8'h32;
  localparam logic [7:0] OP_ROT_INC_A   = 8'h33;
  localparam logic [7:0] OP_ROT_DEC_XA  = 8'h34;
  localparam logic [7:0] OP_ROT_INC_XA  = 8'h35;
  localparam logic [7:0] OP_HALT_X      = 8'h36;
  localparam logic [7:0] OP_SET_IV      = 8'h37;
  localparam logic [7:0] OP_GET_IV      = 8'h38;
  localparam logic [7:0] OP_ACCU_IV     = 8'h39;
  localparam logic [7:0] OP_COND_CALL   = 8'h50;

  // reply status codes
  localparam logic [7:0] STATUS_OK        = 8'h64;
  localparam logic [7:0] STATUS_BAD_CSUM  = 8'h01;
  localparam logic [7:0] STATUS_BAD_CMD   = 8'h02;
  localparam logic [7:0] STATUS_BAD_TYPE  = 8'h03;
  localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;

  localparam int unsigned AXIS_COUNT   = 3;
  localparam logic [7:0]  PARAM_TARGET_VEL = 8'h02;
  localparam logic [31:0] VEL_RESET    = 32'h0000_0000;

  // extended opcode classes, one-hot
  typedef enum logic [8:0] {
    CLS_NONE     = 9'h001,
    CLS_CALC     = 9'h002,
    CLS_MOVE     = 9'h004,
    CLS_RESTART  = 9'h008,
    CLS_BRANCH   = 9'h010,
    CLS_ROTATE   = 9'h020,
    CLS_HALT     = 9'h040,
    CLS_AXIS_PAR = 9'h080,
    CLS_IDX_VAR  = 9'h100
  } op_class_e;

  typedef enum logic [1:0] {
    MODE_POSITION = 2'h1,
    MODE_VELOCITY = 2'h2
  } axis_mode_e;

  // decoded frame
  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  instr;
    logic [7:0]  ctype;
    logic [7:0]  axis;
    logic [31:0] value;
  } frame_s;

  // reply to the host
  typedef struct packed {
    logic [7:0]  addr;
    logic [7:0]  status;
    logic [7:0]  instr;
    logic [31:0] value;
  } reply_s;

endpackage : cmd_pkg

// File: rtl/motion_command_interpreter.sv
// Purpose: assemble command frames, check them and run velocity commands
// Assumes: frame bytes arrive from same-clock logic, one per rx_valid cycle
//          reset is synchronous and held for at least one edge
// Notes:   extended opcodes are decoded and handed out as a class strobe
//          bytes are counted, not framed: a lost byte skews every later frame
//          until reset, and the checksum is what exposes the skew
`timescale 1ns/1ps
`default_nettype none

module motion_command_interpreter
  import cmd_pkg::*;
#(
  parameter int unsigned AXES = AXIS_COUNT
) (
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire logic                 rx_valid,
  input  wire logic [7:0]           rx_byte,
  output logic                      reply_valid,
  output reply_s                    reply,
  output logic [AXES-1:0][31:0]     target_velocity,
  output logic [AXES-1:0]           velocity_mode,
  output logic [AXES-1:0]           soft_halt,
  output logic                      ext_valid,
  output op_class_e                 ext_class,
  output frame_s                    ext_frame
);

  ////////////////////////////////////////////////////////////////////////
  // frame assembly
  // there is no idle timeout; a host that drops a byte must reset the block,
  // trading self-resynchronisation for a plain position counter

  logic [3:0]  byte_idx;
  logic [7:0]  csum;
  frame_s      frame;
  logic        frame_done;
  logic        csum_ok;

  // last byte of a frame arrives; checksum compared against running sum
  // comparing against the sum of bytes 0..7 avoids a ninth adder stage
  // on the path into the reply register
  assign frame_done = rx_valid && (byte_idx == IDX_CSUM);
  assign csum_ok    = (csum == rx_byte);

  // byte counter and running modulo-256 sum
  // the sum clears with the counter, so a rejected frame leaves no residue
  always_ff @(posedge mclk) begin
    if (reset) begin
      byte_idx <= 4'h0;
      csum     <= 8'h00;
    end else if (rx_valid) begin
      if (frame_done) begin
        byte_idx <= 4'h0;
        csum     <= 8'h00;
      end else begin
        byte_idx <= byte_idx + 4'h1;
        csum     <= csum + rx_byte;
      end
    end
  end

  // fields land by position; value shifts in most significant first
  // the checksum byte is not stored; only its comparison matters
  always_ff @(posedge mclk) begin
    if (reset) begin
      frame <= '0;
    end else if (rx_valid) begin
      unique case (byte_idx)
        IDX_ADDR:  frame.addr  <= rx_byte;
        IDX_INSTR: frame.instr <= rx_byte;
        IDX_TYPE:  frame.ctype <= rx_byte;
        IDX_AXIS:  frame.axis  <= rx_byte;
        IDX_CSUM:  ;
        default:   frame.value <= {frame.value[23:0], rx_byte};
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode

  // extended codes are not checked for type or axis here; the program
  // engine downstream owns those fields
  // maps an instruction code onto its extended class
  function automatic op_class_e classify(input logic [7:0] op);
    if (op >= OP_CALC_VV && op <= OP_CALC_V)        return CLS_CALC;
    if (op == OP_MOVE_A || op == OP_MOVE_XA)        return CLS_MOVE;
    if (op == OP_RESTART)                           return CLS_RESTART;
    if (op == OP_DEC_BRANCH || op == OP_COND_CALL)  return CLS_BRANCH;
    if (op >= OP_ROT_DEC_A && op <= OP_ROT_INC_XA)  return CLS_ROTATE;
    if (op == OP_HALT_X)                            return CLS_HALT;
    if (op >= OP_SET_AP_X && op <= OP_ACCU_AP_X)    return CLS_AXIS_PAR;
    if (op >= OP_SET_IV && op <= OP_ACCU_IV)        return CLS_IDX_VAR;
    return CLS_NONE;
  endfunction : classify

  logic       is_inc;
  logic       is_dec;
  logic       is_halt;
  logic       is_velocity;
  logic       type_ok;
  logic       axis_ok;
  op_class_e  cls;
  logic       cmd_go;
  logic [7:0] next_status;

  // the frame register is complete except for the checksum byte
  // type and axis only matter for the three velocity codes
  assign is_inc      = (frame.instr == OP_ROTATE_INCREASING);
  assign is_dec      = (frame.instr == OP_ROTATE_DECREASING);
  assign is_halt     = (frame.instr == OP_AXIS_SOFT_HALT);
  assign is_velocity = is_inc || is_dec || is_halt;
  assign type_ok     = (frame.ctype == 8'h00);
  assign axis_ok     = (frame.axis < 8'(AXES));
  assign cls         = classify(frame.instr);
  assign cmd_go      = frame_done && csum_ok && is_velocity && type_ok && axis_ok;

  // status priority: checksum, unknown code, bad type, bad axis
  // a bad checksum outranks every other fault, since no other field of a
  // corrupted frame can be trusted
  always_comb begin
    next_status = STATUS_OK;
    if (!csum_ok) begin
      next_status = STATUS_BAD_CSUM;
    end else if (!is_velocity && cls == CLS_NONE) begin
      next_status = STATUS_BAD_CMD;
    end else if (is_velocity && !type_ok) begin
      next_status = STATUS_BAD_TYPE;
    end else if (is_velocity && !axis_ok) begin
      next_status = STATUS_BAD_VALUE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-axis velocity state

  // direction travels as the sign of the target; a decreasing rotation at
  // the most negative value wraps onto itself, so hosts should stay inside
  // the symmetric range
  // a refused frame leaves every axis as it was
  // mode and target velocity are written in the same edge; the mode
  // switch is visible no later than the new target
  always_ff @(posedge mclk) begin
    if (reset) begin
      velocity_mode   <= '0;
      target_velocity <= {AXES{VEL_RESET}};
      soft_halt       <= '0;
    end else if (cmd_go) begin
      for (int a = 0; a < AXES; a++) begin
        // only the addressed axis is touched; the others keep their state
        if (frame.axis == 8'(a)) begin
          velocity_mode[a] <= 1'b1;
          // a new rotate clears the soft stop request on that axis
          soft_halt[a]     <= is_halt;
          if (is_inc) begin
            target_velocity[a] <= frame.value;
          end else if (is_dec) begin
            target_velocity[a] <= -frame.value;
          end else begin
            target_velocity[a] <= VEL_RESET;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reply and extended hand-off

  // one reply per frame; value field is don't-care, driven as zero
  // the reply fields stand until the next frame, so a slow host can read
  // them after the strobe has gone
  always_ff @(posedge mclk) begin
    if (reset) begin
      reply_valid <= 1'b0;
      reply       <= '0;
    end else begin
      reply_valid <= frame_done;
      if (frame_done) begin
        reply.addr   <= frame.addr;
        reply.status <= next_status;
        reply.instr  <= frame.instr;
        reply.value  <= 32'h0000_0000;
      end
    end
  end

  // extended opcodes go to the program engine as a one-cycle strobe
  // ext_class and ext_frame follow every frame, refused ones too; only
  // the strobe says whether the engine should act
  always_ff @(posedge mclk) begin
    if (reset) begin
      ext_valid <= 1'b0;
      ext_class <= CLS_NONE;
      ext_frame <= '0;
    end else begin
      ext_valid <= frame_done && csum_ok && (cls != CLS_NONE);
      if (frame_done) begin
        ext_class <= cls;
        ext_frame <= frame;
      end
    end
  end

endmodule : motion_command_interpreter

`default_nettype wire

// File: bench/host_model.sv
// Purpose: host side that sends command frames one byte at a time
// Assumes: bytes change at the falling edge of mclk
// Notes:   an idle byte lane shows the inverse of the last byte
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       mclk,
  output logic            rx_valid,
  output logic [7:0]      rx_byte
);
  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'h00;
  end
  // lane released: invert so a stale byte never looks valid
  task automatic idle;
    @(negedge mclk);
    rx_valid = 1'b0;
    rx_byte  = ~rx_byte;
  endtask : idle
  // eight frame bytes msb first, then their byte sum; bad spoils the sum
  task automatic send(input logic [63:0] f, input logic bad, input logic [1:0] gap);
    logic [7:0] sum;
    sum = 8'h00;
    for (int i = 7; i >= 0; i--) sum = sum + f[i*8 +: 8];
    for (int i = 8; i >= 0; i--) begin
      @(negedge mclk);
      rx_valid = 1'b1;
      rx_byte  = (i > 0) ? f[(i-1)*8 +: 8] : (sum ^ {7'h00, bad});
      if (gap != 2'h0) begin
        idle();
        repeat (gap - 1) @(negedge mclk);
      end
    end
  endtask : send
endmodule : host_model
`default_nettype wire

// File: bench/motion_command_interpreter_checker.sv
// Purpose: port-level assertions for the command interpreter
// Assumes: bytes are counted from reset, nine to a frame
// Notes:   shadow frame kept here so answers can be tied to bytes
`timescale 1ns/1ps
`default_nettype none
module motion_command_interpreter_checker
  import cmd_pkg::*;
#(parameter int unsigned AXES = AXIS_COUNT) (
  input wire logic                 mclk,
  input wire logic                 reset,
  input wire logic                 rx_valid,
  input wire logic [7:0]           rx_byte,
  input wire logic                 reply_valid,
  input wire reply_s               reply,
  input wire logic [AXES-1:0][31:0] target_velocity,
  input wire logic [AXES-1:0]      velocity_mode,
  input wire logic [AXES-1:0]      soft_halt,
  input wire logic                 ext_valid,
  input wire op_class_e            ext_class,
  input wire frame_s               ext_frame
);
  logic [3:0]  cnt;
  logic [63:0] sh;
  logic [7:0]  sum;
  logic [1:0]  ax;
  logic        last;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // byte position and shadow of the first eight bytes
  always_ff @(posedge mclk) begin
    if (reset) cnt <= 4'h0;
    else if (rx_valid) cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
  end
  always_ff @(posedge mclk) begin
    if (rx_valid && cnt != 4'h8) sh <= {sh[55:0], rx_byte};
  end
  always_comb begin
    sum = 8'h00;
    for (int i = 0; i < 8; i++) sum = sum + sh[i*8 +: 8];
  end
  assign ax   = sh[33:32];
  assign last = rx_valid && cnt == 4'h8;
  a_reply_latency: assert property (last |=> reply_valid) else $error("no reply");
  a_reply_spurious: assert property (!last |=> !reply_valid) else $error("stray reply");
  a_rotate_inc: assert property (
    reply_valid && reply.status == STATUS_OK && reply.instr == 8'h01
    |-> velocity_mode[ax] && target_velocity[ax] == sh[31:0] && !soft_halt[ax])
    else $error("rotate up wrong");
  a_rotate_dec: assert property (
    reply_valid && reply.status == STATUS_OK && reply.instr == 8'h02
    |-> velocity_mode[ax] && target_velocity[ax] == -sh[31:0] && !soft_halt[ax])
    else $error("rotate down wrong");
  a_soft_halt: assert property (
    reply_valid && reply.status == STATUS_OK && reply.instr == 8'h03
    |-> velocity_mode[ax] && soft_halt[ax] && target_velocity[ax] == 32'h0)
    else $error("halt wrong");
  a_bad_sum: assert property (
    last && rx_byte != sum |=> reply.status == STATUS_BAD_CSUM
    && !ext_valid && $stable(target_velocity)) else $error("bad sum taken");
  a_ok_fields: assert property (
    reply_valid && reply.status == STATUS_OK |-> reply.value == 32'h0
    && reply.instr == sh[55:48] && reply.addr == sh[63:56]) else $error("reply fields");
  a_ext_halt: assert property (
    last && rx_byte == sum && sh[55:48] == OP_HALT_X
    |=> ext_valid && ext_class == CLS_HALT) else $error("halt by x");
endmodule : motion_command_interpreter_checker
bind motion_command_interpreter motion_command_interpreter_checker #(.AXES(AXES)) u_chk (
  .mclk(mclk), .reset(reset), .rx_valid(rx_valid), .rx_byte(rx_byte),
  .reply_valid(reply_valid), .reply(reply), .target_velocity(target_velocity),
  .velocity_mode(velocity_mode), .soft_halt(soft_halt), .ext_valid(ext_valid),
  .ext_class(ext_class), .ext_frame(ext_frame));
`default_nettype wire

// File: bench/motion_command_interpreter_tb.sv
// Purpose: self-checking bench for the command interpreter
// Assumes: host model drives bytes, notes queue holds expected replies
// Notes:   random velocities and byte gaps come from a fixed lfsr
`timescale 1ns/1ps
`default_nettype none
module motion_command_interpreter_tb;
  import cmd_pkg::*;
  typedef struct packed {
    logic [7:0] st; logic [7:0] ins; logic [1:0] ax; logic [31:0] vel;
    logic vchk; op_class_e cls; logic ext;
  } exp_s;
  logic mclk = 1'b0, reset = 1'b1, rx_valid, reply_valid, ext_valid;
  logic [7:0] rx_byte;
  reply_s reply;
  logic [2:0][31:0] target_velocity;
  logic [2:0] velocity_mode, soft_halt;
  op_class_e ext_class;
  frame_s ext_frame;
  exp_s q[$], w;
  int fails = 0, num_checks = 0;
  logic [31:0] lfsr = 32'h0000_0023;
  always #5 mclk = ~mclk;
  host_model u_host (.mclk(mclk), .rx_valid(rx_valid), .rx_byte(rx_byte));
  motion_command_interpreter u_dut (.mclk(mclk), .reset(reset), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .reply_valid(reply_valid), .reply(reply),
    .target_velocity(target_velocity), .velocity_mode(velocity_mode),
    .soft_halt(soft_halt), .ext_valid(ext_valid), .ext_class(ext_class),
    .ext_frame(ext_frame));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // codes 16..18, 40..57 and 80 are extended; anything else is unknown
  function automatic op_class_e cls(input logic [7:0] o);
    if (o >= 8'd16 && o <= 8'd18) return CLS_AXIS_PAR;
    if (o >= 8'd40 && o <= 8'd45) return CLS_CALC;
    if (o == 8'd46 || o == 8'd47) return CLS_MOVE;
    if (o == 8'd48) return CLS_RESTART;
    if (o == 8'd49 || o == 8'd80) return CLS_BRANCH;
    if (o >= 8'd50 && o <= 8'd53) return CLS_ROTATE;
    if (o == 8'd54) return CLS_HALT;
    if (o >= 8'd55 && o <= 8'd57) return CLS_IDX_VAR;
    return CLS_NONE;
  endfunction : cls
  // random source for velocities and byte gaps
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // note the expected answer first, then hand the frame to the host
  task automatic cmd(input logic [7:0] ins, typ, ax, input logic [31:0] v, input logic bad);
    exp_s e;
    e = '{STATUS_OK, ins, ax[1:0], v, 1'b0, CLS_NONE, 1'b0};
    if (bad) e.st = STATUS_BAD_CSUM;
    else if (ins >= 8'h01 && ins <= 8'h03) begin
      if (typ != 8'h00) e.st = STATUS_BAD_TYPE;
      else if (ax >= 8'h03) e.st = STATUS_BAD_VALUE;
      else e.vchk = 1'b1;
      e.vel = (ins == 8'h02) ? -v : (ins == 8'h03) ? 32'h0 : v;
    end else if (cls(ins) == CLS_NONE) e.st = STATUS_BAD_CMD;
    else {e.cls, e.ext} = {cls(ins), 1'b1};
    q.push_back(e);
    lfsr = lfsr_next(lfsr);
    u_host.send({8'h01, ins, typ, ax, v}, bad, lfsr[1:0]);
  endtask : cmd
  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////////
  // results are read at the falling edge, after the answering edge settled
  always @(negedge mclk) begin
    if (reply_valid === 1'b1) begin
      w = q.pop_front();
      chk("status", w.st, reply.status);
      chk("instr", w.ins, reply.instr);
      chk("value", 64'h0, reply.value);
      chk("addr", 64'h01, reply.addr);
      if (w.ext) chk("ext frame", {8'h01, w.ins, 16'h0000, w.vel}, ext_frame);
      chk("ext", w.ext, ext_valid);
      if (w.ext) chk("class", w.cls, ext_class);
      if (w.vchk) begin
        chk("velocity", w.vel, target_velocity[w.ax]);
        chk("mode", 1, velocity_mode[w.ax]);
        chk("halt", w.ins == 8'h03, soft_halt[w.ax]);
      end
    end
  end
  // 101 frames, nine bytes each with up to three idle cycles behind
  // every byte: 36 cycles a frame, so 150 frames of 40 cycles is ample
  initial begin
    #(150 * 40 * 10);
    fails++;
    wrap_up();
  end
  initial begin
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    cmd(8'h01, 8'h00, 8'h00, 32'h0000_C800, 1'b0);
    for (int a = 0; a < 3; a++)
      for (int k = 1; k <= 3; k++) cmd(k[7:0], 8'h00, a[7:0], lfsr, 1'b0);
    $display("velocity test done");
    cmd(8'h01, 8'h00, 8'h01, lfsr, 1'b1);
    cmd(8'h02, 8'h01, 8'h00, lfsr, 1'b0);
    cmd(8'h01, 8'h00, 8'h03, lfsr, 1'b0);
    $display("refusal test done");
    // mid-run reset with the lane idle: every axis output falls back to zero
    u_host.idle();
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    chk("reset flags", 0, {reply_valid, ext_valid, velocity_mode, soft_halt});
    for (int a = 0; a < 3; a++) chk("reset velocity", 0, target_velocity[a]);
    reset = 1'b0;
    $display("reset test done");
    // every code up to 90 but the velocity ones: known extended codes are
    // forwarded, the rest are refused as unknown
    for (int o = 0; o <= 90; o++)
      if (o == 0 || o > 3) cmd(o[7:0], 8'h00, 8'h00, lfsr, 1'b0);
    u_host.idle();
    repeat (4) @(negedge mclk);
    chk("pending", 0, q.size());
    $display("extended test done");
    wrap_up();
  end
endmodule : motion_command_interpreter_tb
`default_nettype wire
